// file: src/ltr_pkg.sv
// package for the line thermal replica block: settings, modes, number formats
package ltr_pkg;
	localparam int TEMP_W = 16;          // degrees, unsigned, integer part
	localparam int FRAC_W = 16;          // fraction bits of relative heat level
	localparam int CUR_W  = 16;          // current in percent of rated

	localparam logic [TEMP_W-1:0] ALARM_TEMP_DEF   = 16'h0050; // 80 deg
	localparam logic [TEMP_W-1:0] TRIP_TEMP_DEF    = 16'h0064; // 100 deg
	localparam logic [TEMP_W-1:0] RATED_TEMP_DEF   = 16'h0064; // 100 deg
	localparam logic [TEMP_W-1:0] BASE_TEMP_DEF    = 16'h0019; // 25 deg
	localparam logic [TEMP_W-1:0] UNLOCK_TEMP_DEF  = 16'h003C; // 60 deg
	localparam logic [TEMP_W-1:0] AMBIENT_TEMP_DEF = 16'h0019; // 25 deg
	// setting spans; a setting outside its span is pulled to the nearest limit
	localparam logic [TEMP_W-1:0] TEMP_SET_MIN     = 16'h003C; // 60 deg
	localparam logic [TEMP_W-1:0] TEMP_SET_MAX     = 16'h00C8; // 200 deg
	localparam logic [TEMP_W-1:0] UNLOCK_SET_MIN   = 16'h0014; // 20 deg
	localparam logic [TEMP_W-1:0] AMBIENT_SET_MIN  = 16'h0000; // 0 deg
	localparam logic [TEMP_W-1:0] AMBIENT_SET_MAX  = 16'h0028; // 40 deg
	localparam logic [7:0]        STARTUP_TERM_DEF = 8'h00;    // percent
	localparam logic [CUR_W-1:0]  RATED_CUR_DEF    = 16'h0064; // 100 percent
	localparam logic [CUR_W-1:0]  TIME_CONST_DEF   = 16'h000A; // minutes

	localparam int STEP_TIME_MS = 20;            // calculation step
	localparam int CLK_HZ       = 50_000_000;
	localparam int STEP_CYCLES  = (CLK_HZ / 1000) * STEP_TIME_MS;

	typedef enum logic [2:0] {
		LTR_OFF    = 3'b001,
		LTR_PULSED = 3'b010,
		LTR_LOCKED = 3'b100
	} ltr_mode_t;

	typedef struct packed {
		ltr_mode_t         operating_mode_setting;
		logic [TEMP_W-1:0] alarm_temp_setting;
		logic [TEMP_W-1:0] trip_temp_setting;
		logic [TEMP_W-1:0] rated_temp_setting;
		logic [TEMP_W-1:0] base_temp_setting;
		logic [TEMP_W-1:0] unlock_temp_setting;
		logic [TEMP_W-1:0] ambient_temp_setting;
		logic [7:0]        startup_term_setting;
		logic [CUR_W-1:0]  rated_load_current_setting;
		logic [CUR_W-1:0]  time_constant_setting;
		logic              ambient_sensor_select;
	} ltr_cfg_t;

	typedef struct packed {
		logic alarm_out;
		logic general_trip_out;
		logic reclose_lock_out;
	} ltr_out_t;
endpackage : ltr_pkg

// file: src/ltr_line_thermal_function.sv
// line thermal replica: heat model, threshold decisions, trip and lock outputs
`timescale 1ns/1ps
// Function
// [R1] periodically step temperature model, compare thresholds
// [R2] upstream supplies maximum phase RMS current
// [R3] ambient from sensor or fixed setting
// [R4] mode off, pulsed, locked; pulsed at reset
// [R5] off mode keeps all outputs inactive; code clears status_out only, temp output still updates
// [R6] pulsed mode: one trip pulse on rise
// [R7] locked: hold trip until below unlock
// [R8] threshold ranges and defaults as specified
// [R9] block input disables whole function; code only clears status outputs and locked state, heat model keeps stepping
// [R10] heat reset forces starting temperature
// [R11] alarm, trip and reclose lock outputs
// [R12] calculated temperature always readable
// [R13] heat step: H*(1-dt/T) + dt/T*(I/In)^2
// [R14] upstream RMS sampled at 1 kHz
// [R15] alarm while above alarm, enabled
// [R16] reclose lock follows held locked trip
module ltr_line_thermal_function
	import ltr_pkg::*;
#(
	parameter int STEP_CYC = STEP_CYCLES
) (
	input  wire logic              ref_clk,
	input  wire logic              resetn,
	input  wire logic [CUR_W-1:0]  max_current_in,
	input  wire logic [TEMP_W-1:0] ambient_temp_in,
	input  wire ltr_cfg_t          cfg,
	input  wire logic              block_in,
	input  wire logic              heat_reset_in,
	output      ltr_out_t          status_out,
	output      logic [TEMP_W-1:0] calculated_temp_value
);
	localparam int HW = 2 * FRAC_W;       // heat level, FRAC_W fraction bits
	localparam int CW = $clog2(STEP_CYC + 1);
	localparam logic [HW-1:0] ONE = 32'h0001_0000;

	// user logic inputs come from outside this clock domain
	logic [1:0] blk_sync;
	logic [1:0] rst_sync;
	logic       blk;
	logic       hrst;
	assign blk  = blk_sync[1];
	assign hrst = rst_sync[1];

	logic [CW-1:0]     cnt;
	logic [CW-1:0]     next_cnt;
	logic [HW-1:0]     heat;
	logic [HW-1:0]     next_heat;
	logic              tripped;
	logic              next_tripped;
	ltr_out_t          outs;
	ltr_out_t          next_outs;
	logic [TEMP_W-1:0] temp;
	logic [TEMP_W-1:0] next_temp;

	// per-step arithmetic
	logic [63:0] ratio;
	logic [63:0] sq;
	logic [63:0] k;
	logic [63:0] decay;
	logic [63:0] gain;
	logic [63:0] rise;
	logic [63:0] start_heat;
	logic [TEMP_W-1:0] ambient;
	logic        step;

	// settings outside their allowed span are pulled to the nearest limit;
	// nothing stops an unlock level above the trip level, which then releases
	// the locked trip as soon as the temperature is no longer above the trip level
	logic [TEMP_W-1:0] alarm_lim;
	logic [TEMP_W-1:0] trip_lim;
	logic [TEMP_W-1:0] unlock_lim;
	logic [TEMP_W-1:0] amb_fix;

	function automatic logic [TEMP_W-1:0] clamp_temp(
		input logic [TEMP_W-1:0] v,
		input logic [TEMP_W-1:0] lo,
		input logic [TEMP_W-1:0] hi
	);
		logic [TEMP_W-1:0] r;
		r = v;
		if (v < lo) begin
			r = lo;
		end else if (v > hi) begin
			r = hi;
		end
		return r;
	endfunction : clamp_temp

	always_comb begin
		alarm_lim  = clamp_temp(cfg.alarm_temp_setting, TEMP_SET_MIN, TEMP_SET_MAX);   // see [R8]
		trip_lim   = clamp_temp(cfg.trip_temp_setting, TEMP_SET_MIN, TEMP_SET_MAX);    // see [R8]
		unlock_lim = clamp_temp(cfg.unlock_temp_setting, UNLOCK_SET_MIN, TEMP_SET_MAX); // see [R8]
		// only the fixed setting is limited; a sensor value is taken as it comes
		amb_fix    = clamp_temp(cfg.ambient_temp_setting, AMBIENT_SET_MIN, AMBIENT_SET_MAX);
	end

	always_comb begin
		// ratio I/In in FRAC_W fraction bits
		if (cfg.rated_load_current_setting == '0) begin
			ratio = '0;
		end else begin
			ratio = ({48'h0, max_current_in} << FRAC_W) / {48'h0, cfg.rated_load_current_setting};
		end
		// clamp keeps the square inside 64 bits
		if (ratio > 64'h0000_0000_00FF_FFFF) begin
			ratio = 64'h0000_0000_00FF_FFFF;
		end
		sq = (ratio * ratio) >> FRAC_W;
		// dt/T with T in minutes; dt in ms
		if (cfg.time_constant_setting == '0) begin
			k = {32'h0, ONE};
		end else begin
			k = ({32'h0, 32'(STEP_TIME_MS)} << FRAC_W) /
			    ({48'h0, cfg.time_constant_setting} * 64'h0000_0000_0000_EA60);
		end
		// heat and k carry FRAC_W fraction bits; each product is shifted back
		decay = ({32'h0, heat} * ({32'h0, ONE} - k)) >> FRAC_W;           // see [R13]
		gain  = (sq * k) >> FRAC_W;                                       // see [R13]
		// start value is the startup term as a share of the rated rise
		start_heat = ({56'h0, cfg.startup_term_setting} << FRAC_W) / 64'h0000_0000_0000_0064;
		ambient = cfg.ambient_sensor_select ? ambient_temp_in : amb_fix;  // see [R3]
		// rated temperature is the rise reached at rated current
		rise = ({32'h0, heat} * {48'h0, cfg.rated_temp_setting}) >> FRAC_W;
	end

	always_comb begin
		// counter runs from reset: the first step comes STEP_CYC edges after release
		step      = (cnt == CW'(STEP_CYC - 1));
		next_cnt  = step ? '0 : cnt + CW'(1);                             // see [R1]
		next_heat = heat;
		// a heat reset outranks a step that falls in the same cycle
		if (hrst) begin
			next_heat = start_heat[HW-1:0];                           // see [R10]
		end else if (step) begin
			if (decay + gain > {32'h0, 32'hFFFF_FFFF}) begin
				next_heat = 32'hFFFF_FFFF;
			end else begin
				next_heat = 32'(decay + gain);                    // see [R1]
			end
		end
		// measured temperature is rise above ambient plus ambient
		if (rise + {48'h0, ambient} > 64'h0000_0000_0000_FFFF) begin
			next_temp = 16'hFFFF;
		end else begin
			next_temp = 16'(rise) + ambient;                          // see [R12]
		end
	end

	// decisions read the registered temperature, so status lags it one cycle;
	// block or off mode also drops the locked state so it is not carried over
	always_comb begin
		next_tripped = tripped;
		next_outs    = '0;
		if (blk || cfg.operating_mode_setting == LTR_OFF) begin       // see [R5] see [R9]
			next_tripped = 1'b0;
		end else begin
			next_outs.alarm_out = temp > alarm_lim;                   // see [R15] see [R11]
			unique case (cfg.operating_mode_setting)                 // see [R4]
			LTR_PULSED: begin
				// tripped marks "already above" so only one pulse per crossing
				next_tripped = temp > trip_lim;
				next_outs.general_trip_out = next_tripped && !tripped; // see [R6]
			end
			LTR_LOCKED: begin
				// setting outranks release when both limits are met
				if (temp > trip_lim) begin
					next_tripped = 1'b1;                      // see [R7]
				end else if (temp < unlock_lim) begin
					next_tripped = 1'b0;                      // see [R7]
				end
				next_outs.general_trip_out = next_tripped;
				next_outs.reclose_lock_out = next_tripped;        // see [R16]
			end
			default: begin
				next_tripped = 1'b0;
			end
			endcase
		end
	end

	// only the second stage of each synchroniser is read by the logic
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			blk_sync <= 2'h0;
			rst_sync <= 2'h0;
		end else begin
			blk_sync <= {blk_sync[0], block_in};
			rst_sync <= {rst_sync[0], heat_reset_in};
		end
	end

	// heat model: step counter, heat level and measured temperature
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cnt  <= '0;
			heat <= '0;
			temp <= '0;
		end else begin
			cnt  <= next_cnt;
			heat <= next_heat;
			temp <= next_temp;
		end
	end

	// decision state and the registered status outputs
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tripped <= 1'b0;
			outs    <= '0;
		end else begin
			tripped <= next_tripped;
			outs    <= next_outs;
		end
	end

	assign status_out            = outs;
	assign calculated_temp_value = temp;
endmodule : ltr_line_thermal_function

// file: bench/ltr_checker_asserts.sv
// port checker for the line thermal replica
`timescale 1ns/1ps
module ltr_checker import ltr_pkg::*; (
	input wire logic              ref_clk,
	input wire logic              resetn,
	input wire logic [TEMP_W-1:0] ambient_temp_in,
	input wire ltr_cfg_t          cfg,
	input wire logic              block_in,
	input wire logic              heat_reset_in,
	input wire ltr_out_t          status_out,
	input wire logic [TEMP_W-1:0] calculated_temp_value
);
	ltr_mode_t         m;
	logic [TEMP_W-1:0] t;
	assign m = cfg.operating_mode_setting;
	assign t = calculated_temp_value;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	off_quiet_a: assert property (
		$past(m) == LTR_OFF |-> status_out == 3'h0)
		else $error("output active in off mode");
	trip_cause_a: assert property (
		$rose(status_out.general_trip_out) |-> $past(t) > cfg.trip_temp_setting)
		else $error("trip without hot conductor");
	pulse_width_a: assert property (
		status_out.general_trip_out && $past(m) == LTR_PULSED
		|=> !status_out.general_trip_out)
		else $error("trip pulse too long");
	alarm_cause_a: assert property (
		status_out.alarm_out |-> $past(t) > cfg.alarm_temp_setting)
		else $error("alarm below threshold");
	lock_follow_a: assert property (
		m == LTR_LOCKED && $stable(m)
		|-> status_out.reclose_lock_out == status_out.general_trip_out)
		else $error("reclose lock differs from held trip");
	block_quiet_a: assert property (
		block_in [*6] |-> status_out == 3'h0)
		else $error("output active while blocked");
	heat_start_a: assert property (
		heat_reset_in [*6] ##0 cfg.startup_term_setting == 8'h00
		|-> t == (cfg.ambient_sensor_select ? ambient_temp_in : cfg.ambient_temp_setting))
		else $error("temperature not at start value");
	lock_hold_a: assert property (
		!block_in [*5] ##0 (m == LTR_LOCKED && status_out.general_trip_out
		&& t >= cfg.unlock_temp_setting) |=> status_out.general_trip_out)
		else $error("locked trip released early");
endmodule : ltr_checker

// file: bench/ltr_upstream_model.sv
// upstream stage model: forwards the largest phase rms current
`timescale 1ns/1ps
module ltr_upstream_model import ltr_pkg::*; (
	input wire logic                  ref_clk,
	input wire logic [2:0][CUR_W-1:0] phase_rms,
	output     logic [CUR_W-1:0]      max_rms
);
	logic [CUR_W-1:0] mx;
	// each new phase set stands for one finished 1 kHz rms window
	always @(posedge ref_clk) begin
		mx = phase_rms[0];
		for (int i = 1; i < 3; i++) if (phase_rms[i] > mx) mx = phase_rms[i];
		max_rms <= mx;
	end
endmodule : ltr_upstream_model

// file: bench/tb_top.sv
// random and corner-case bench for the line thermal replica
`timescale 1ns/1ps
module tb_top;
	import ltr_pkg::*;
	logic                  ref_clk = 0;
	logic                  resetn = 0;
	logic [2:0][CUR_W-1:0] ph = '0;
	logic [CUR_W-1:0]      cur;
	logic [TEMP_W-1:0]     amb = 16'h001E;
	logic                  blk = 0;
	logic                  hr = 0;
	ltr_out_t              st;
	logic [TEMP_W-1:0]     temp;
	int                    fails = 0, checks = 0, cyc = 0, rises = 0, n;
	int                    seed = 32'hF7E5ED72;
	ltr_mode_t             md[3] = '{LTR_OFF, LTR_PULSED, LTR_LOCKED};
	ltr_cfg_t              cfg = {LTR_PULSED, ALARM_TEMP_DEF, TRIP_TEMP_DEF, RATED_TEMP_DEF,
		BASE_TEMP_DEF, UNLOCK_TEMP_DEF, AMBIENT_TEMP_DEF, STARTUP_TERM_DEF, RATED_CUR_DEF,
		TIME_CONST_DEF, 1'b0};
	always #10 ref_clk = ~ref_clk;
	ltr_upstream_model up (.ref_clk(ref_clk), .phase_rms(ph), .max_rms(cur));
	// short step keeps the run small; heating still uses the 20 ms step size
	ltr_line_thermal_function #(.STEP_CYC(50)) dut (.ref_clk(ref_clk), .resetn(resetn),
		.max_current_in(cur), .ambient_temp_in(amb), .cfg(cfg), .block_in(blk),
		.heat_reset_in(hr), .status_out(st), .calculated_temp_value(temp));
	function automatic int exp_rises(input ltr_mode_t m);
		return (m != LTR_OFF) ? 1 : 0;
	endfunction : exp_rises
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic give_verdict();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : give_verdict
	task automatic cool();
		hr <= 1;
		ph <= '0;
		repeat (9) @(posedge ref_clk);
		hr <= 0;
		@(posedge ref_clk);
	endtask : cool
	always @(posedge ref_clk) begin
		cyc++;
		if ($rose(st.general_trip_out)) rises++;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		resetn <= 1;
		repeat (3) @(posedge ref_clk);
		chk("temp after reset", AMBIENT_TEMP_DEF, temp);
		cfg.ambient_sensor_select <= 1;
		cool();
		chk("sensor ambient", amb, temp);
		cfg.ambient_sensor_select <= 0;
		foreach (md[j]) begin
			cool();
			chk("temp after heat reset", AMBIENT_TEMP_DEF, temp);
			chk("idle status", 16'h0000, 16'(st));
			cfg.operating_mode_setting <= md[j];
			n = rises;
			// random heavy load drives the model well past the trip level
			repeat (3000) begin
				@(posedge ref_clk);
				for (int i = 0; i < 3; i++) ph[i] <= 16'h0B00 + 16'({$random(seed)} % 256);
			end
			chk("trip rises", 16'(exp_rises(md[j])), 16'(rises - n));
			chk("heated above trip", 16'h0001, 16'(temp > TRIP_TEMP_DEF));
			chk("alarm", md[j] != LTR_OFF, st.alarm_out);
			chk("reclose lock", md[j] == LTR_LOCKED, st.reclose_lock_out);
			blk <= 1;
			repeat (8) @(posedge ref_clk);
			chk("blocked status", 16'h0000, 16'(st));
			blk <= 0;
		end
		cool();
		chk("released status", 16'h0000, 16'(st));
		give_verdict();
	end
endmodule : tb_top
bind ltr_line_thermal_function ltr_checker chk_i (.ref_clk(ref_clk), .resetn(resetn),
	.ambient_temp_in(ambient_temp_in), .cfg(cfg), .block_in(block_in),
	.heat_reset_in(heat_reset_in), .status_out(status_out),
	.calculated_temp_value(calculated_temp_value));
